// ---- design/input_function_pkg.sv ----
// Constants for the multi-function input decoder
package input_function_pkg;
  localparam int          NUM_INPUTS     = 8;
  localparam int          CODE_W         = 8;
  localparam logic [7:0]  CODE_EXT_FIRST = 8'h20;
  localparam logic [7:0]  CODE_EXT_LAST  = 8'h2F;
  localparam logic [7:0]  CODE_DC_BRAKE  = 8'h60;
  localparam logic [7:0]  CODE_SEARCH_MAX = 8'h61;
  localparam logic [7:0]  CODE_SEARCH_REF = 8'h62;
  localparam logic [7:0]  CODE_TORQUE_SEL = 8'h71;
  localparam logic [7:0]  CODE_ZERO_SERVO = 8'h72;
  localparam logic [7:0]  CODE_GAIN_SW    = 8'h77;
  localparam logic [7:0]  CODE_MINOR_FLT  = 8'h10;
  // Field positions within an external fault code
  localparam int          EXT_NC_BIT     = 0;
  localparam int          EXT_RUNONLY_BIT = 1;
  localparam int          EXT_ACT_LSB    = 2;
  // Stop actions
  localparam logic [1:0]  ACT_DECEL      = 2'h0;
  localparam logic [1:0]  ACT_COAST      = 2'h1;
  localparam logic [1:0]  ACT_ESTOP      = 2'h2;
  localparam logic [1:0]  ACT_ALARM      = 2'h3;
  // Register map
  localparam logic [3:0]  ADDR_CODE_LO   = 4'h0;
  localparam logic [3:0]  ADDR_CODE_HI   = 4'h1;
  localparam logic [3:0]  ADDR_CTRL      = 4'h2;
  localparam logic [3:0]  ADDR_STATUS    = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_EN    = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_CLR   = 4'h6;
  // Control bits
  localparam int          CTRL_FLUX_BIT  = 0;
  localparam int          CTRL_OUTFN_LSB = 8;
  // Interrupt bits
  localparam int          IRQ_FAULT      = 0;
  localparam int          IRQ_ALARM      = 1;
  localparam int          IRQ_CFG_ERR    = 2;
  localparam int          IRQ_W          = 3;
  // Minimum baseblock time
  localparam int          MIN_BB_NS      = 500000;
  localparam int          CLK_NS         = 20;
  localparam int          MIN_BB_CYC     = (MIN_BB_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {S_IDLE, S_WAIT_BB, S_SEARCH} search_t;
endpackage

// ---- design/drive_input_function_decoder.sv ----
// Multi-function digital input decoder for a motor drive
// Notes on behaviour
// - Codes 20..2F select external fault variants
// - Even codes detect ON, odd detect OFF
// - Last two of each four: running only
// - Code group selects the stop action
// - Decel action: fault, normal ramp down
// - Coast action: fault, output cut immediately
// - Emergency action: fault, fast-stop ramp
// - Continue action: alarm only, keep running
// - Output coded 10 shows alarm
// - Duplicate external fault code is refused
// - Code 60 stopped: DC brake or excitation
// - Run or jog ends DC braking
// - 61 searches from max, 62 from reference
// - Run after search: wait baseblock, search
// - Both search codes assigned is invalid
// - Code 71 selects torque control when ON
// - Code 72 locks position below zero speed
// - Code 77 forces second proportional gain
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_decoder #(
  parameter int NUM_IN = input_function_pkg::NUM_INPUTS,
  parameter int BB_CYC = input_function_pkg::MIN_BB_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic [NUM_IN-1:0] din_i,
  input  wire logic              run_cmd_i,
  input  wire logic              jog_cmd_i,
  input  wire logic              fault_reset_i,
  input  wire logic              ref_below_zero_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   fault_o,
  output logic                   alarm_o,
  output logic                   minor_fault_out_o,
  output logic                   decel_stop_o,
  output logic                   coast_o,
  output logic                   fast_stop_o,
  output logic                   dc_brake_o,
  output logic                   init_excite_o,
  output logic                   search_start_o,
  output logic                   search_from_max_o,
  output logic                   torque_mode_o,
  output logic                   zero_servo_o,
  output logic                   speed_gain_second_o,
  output logic                   cfg_error_o,
  output logic                   irq_o
);
  localparam int CW = input_function_pkg::CODE_W;
  localparam int BBW = $clog2(BB_CYC + 1);

  // Three-stage input synchronisers
  logic [NUM_IN-1:0] din_s1_q, din_s2_q, din_s3_q, din_q;
  logic [3:0] ctl_s1_q, ctl_s2_q, ctl_s3_q, ctl_q;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      din_s3_q <= '0;
      din_q    <= '0;
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
      ctl_s3_q <= '0;
      ctl_q    <= '0;
    end
    else
    begin
      din_s1_q <= din_i;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      for (int i = 0; i < NUM_IN; i++)
        if (din_s2_q[i] == din_s3_q[i])
          din_q[i] <= din_s3_q[i];
      ctl_s1_q <= {ref_below_zero_i, fault_reset_i, jog_cmd_i, run_cmd_i};
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
      for (int i = 0; i < 4; i++)
        if (ctl_s2_q[i] == ctl_s3_q[i])
          ctl_q[i] <= ctl_s3_q[i];
    end
  end
  wire run_w   = ctl_q[0];
  wire jog_w   = ctl_q[1];
  wire frst_w  = ctl_q[2];
  wire below_w = ctl_q[3];

  // Registers
  logic [CW-1:0] code_q [NUM_IN];
  logic          flux_q;
  logic [CW-1:0] outfn_q;
  logic [input_function_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q;

  function automatic logic is_ext(input logic [CW-1:0] c);
    return c >= input_function_pkg::CODE_EXT_FIRST && c <= input_function_pkg::CODE_EXT_LAST;
  endfunction

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NUM_IN; i++)
        code_q[i] <= '0;
      flux_q  <= 1'b0;
      outfn_q <= '0;
      irq_en_q <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == input_function_pkg::ADDR_CODE_LO)
      begin
        for (int i = 0; i < 4 && i < NUM_IN; i++)
          code_q[i] <= reg_wdata_i[i*CW +: CW];
      end
      else if (reg_addr_i == input_function_pkg::ADDR_CODE_HI)
      begin
        for (int i = 4; i < NUM_IN; i++)
          code_q[i] <= reg_wdata_i[(i-4)*CW +: CW];
      end
      else if (reg_addr_i == input_function_pkg::ADDR_CTRL)
      begin
        flux_q  <= reg_wdata_i[input_function_pkg::CTRL_FLUX_BIT];
        outfn_q <= reg_wdata_i[input_function_pkg::CTRL_OUTFN_LSB +: CW];
      end
      else if (reg_addr_i == input_function_pkg::ADDR_IRQ_EN)
        irq_en_q <= reg_wdata_i[input_function_pkg::IRQ_W-1:0];
    end
  end

  // Configuration check and decode
  logic cfg_err_d;
  logic [3:0] ext_raw_d [NUM_IN];
  logic ext_hit_d;
  logic [1:0] ext_act_d;
  logic dcb_in_d, smax_in_d, sref_in_d, tq_in_d, zs_in_d, gain_in_d;
  logic any_search_cfg_d;
  always_comb
  begin
    int nmax, nref;
    nmax = 0;
    nref = 0;
    cfg_err_d = 1'b0;
    ext_hit_d = 1'b0;
    ext_act_d = input_function_pkg::ACT_DECEL;
    dcb_in_d = 1'b0;
    smax_in_d = 1'b0;
    sref_in_d = 1'b0;
    tq_in_d = 1'b0;
    zs_in_d = 1'b0;
    gain_in_d = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      ext_raw_d[i] = code_q[i][3:0];
      for (int j = i + 1; j < NUM_IN; j++)
        if (is_ext(code_q[i]) && code_q[i] == code_q[j])
          cfg_err_d = 1'b1;
      if (code_q[i] == input_function_pkg::CODE_SEARCH_MAX)
        nmax = nmax + 1;
      if (code_q[i] == input_function_pkg::CODE_SEARCH_REF)
        nref = nref + 1;
    end
    if (nmax > 0 && nref > 0)
      cfg_err_d = 1'b1;
    any_search_cfg_d = (nmax + nref) > 0;
    // Highest-index active external fault wins
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (is_ext(code_q[i]))
      begin
        if ((din_q[i] ^ ext_raw_d[i][input_function_pkg::EXT_NC_BIT])
            && (!ext_raw_d[i][input_function_pkg::EXT_RUNONLY_BIT] || run_w))
        begin
          ext_hit_d = 1'b1;
          ext_act_d = ext_raw_d[i][input_function_pkg::EXT_ACT_LSB +: 2];
        end
      end
      else if (din_q[i])
      begin
        if (code_q[i] == input_function_pkg::CODE_DC_BRAKE)
          dcb_in_d = 1'b1;
        else if (code_q[i] == input_function_pkg::CODE_SEARCH_MAX)
          smax_in_d = 1'b1;
        else if (code_q[i] == input_function_pkg::CODE_SEARCH_REF)
          sref_in_d = 1'b1;
        else if (code_q[i] == input_function_pkg::CODE_TORQUE_SEL)
          tq_in_d = 1'b1;
        else if (code_q[i] == input_function_pkg::CODE_ZERO_SERVO)
          zs_in_d = 1'b1;
        else if (code_q[i] == input_function_pkg::CODE_GAIN_SW)
          gain_in_d = 1'b1;
      end
    end
    if (cfg_err_d)
      ext_hit_d = 1'b0;
  end
  wire alarm_hit_w = ext_hit_d && ext_act_d == input_function_pkg::ACT_ALARM;
  wire fault_hit_w = ext_hit_d && ext_act_d != input_function_pkg::ACT_ALARM;

  // Latched fault and its stop action
  logic frst_prev_q;
  logic [1:0] fault_act_q;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fault_o      <= 1'b0;
      fault_act_q  <= input_function_pkg::ACT_DECEL;
      frst_prev_q  <= 1'b0;
    end
    else
    begin
      frst_prev_q <= frst_w;
      if (fault_hit_w && !fault_o)
      begin
        fault_o     <= 1'b1;
        fault_act_q <= ext_act_d;
      end
      else if (fault_o && frst_w && !frst_prev_q && !run_w && !fault_hit_w)
        fault_o <= 1'b0;
    end
  end

  // Stop commands, alarm and mode outputs
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      decel_stop_o        <= 1'b0;
      coast_o             <= 1'b0;
      fast_stop_o         <= 1'b0;
      alarm_o             <= 1'b0;
      minor_fault_out_o   <= 1'b0;
      torque_mode_o       <= 1'b0;
      zero_servo_o        <= 1'b0;
      speed_gain_second_o <= 1'b0;
      cfg_error_o         <= 1'b0;
    end
    else
    begin
      decel_stop_o <= fault_o && fault_act_q == input_function_pkg::ACT_DECEL;
      coast_o      <= fault_o && fault_act_q == input_function_pkg::ACT_COAST;
      fast_stop_o  <= fault_o && fault_act_q == input_function_pkg::ACT_ESTOP;
      alarm_o      <= alarm_hit_w;
      minor_fault_out_o <= alarm_hit_w
                           && outfn_q == input_function_pkg::CODE_MINOR_FLT;
      torque_mode_o       <= tq_in_d;
      zero_servo_o        <= zs_in_d && below_w;
      speed_gain_second_o <= gain_in_d;
      cfg_error_o         <= cfg_err_d;
    end
  end

  // DC braking / initial excitation while stopped
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dc_brake_o    <= 1'b0;
      init_excite_o <= 1'b0;
    end
    else
    begin
      dc_brake_o    <= dcb_in_d && !run_w && !jog_w && !fault_o && !flux_q;
      init_excite_o <= dcb_in_d && !run_w && !jog_w && !fault_o && flux_q;
    end
  end

  // External speed search sequencer
  input_function_pkg::search_t st_q;
  logic [BBW-1:0] bb_cnt_q;
  logic           armed_q;
  logic           run_prev_q;
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q              <= input_function_pkg::S_IDLE;
      bb_cnt_q          <= '0;
      armed_q           <= 1'b0;
      run_prev_q        <= 1'b0;
      search_start_o    <= 1'b0;
      search_from_max_o <= 1'b0;
    end
    else
    begin
      run_prev_q     <= run_w;
      search_start_o <= 1'b0;
      if (!(smax_in_d || sref_in_d))
        armed_q <= 1'b0;
      else if (!run_w)
        armed_q <= 1'b1;
      case (st_q)
        input_function_pkg::S_IDLE:
        begin
          if (armed_q && run_w && !run_prev_q && any_search_cfg_d && !cfg_err_d)
          begin
            st_q              <= input_function_pkg::S_WAIT_BB;
            bb_cnt_q          <= '0;
            search_from_max_o <= smax_in_d;
          end
        end
        input_function_pkg::S_WAIT_BB:
        begin
          if (!run_w || fault_o)
            st_q <= input_function_pkg::S_IDLE;
          else if (bb_cnt_q == BBW'(BB_CYC - 1))
          begin
            st_q           <= input_function_pkg::S_SEARCH;
            search_start_o <= 1'b1;
          end
          else
            bb_cnt_q <= bb_cnt_q + 1'b1;
        end
        input_function_pkg::S_SEARCH:
        begin
          if (!run_w)
            st_q <= input_function_pkg::S_IDLE;
        end
        default:
          st_q <= input_function_pkg::S_IDLE;
      endcase
    end
  end

  // Interrupt status: set wins over clear
  logic [input_function_pkg::IRQ_W-1:0] ev_d, clr_d;
  always_comb
  begin
    ev_d = '0;
    ev_d[input_function_pkg::IRQ_FAULT]   = fault_hit_w && !fault_o;
    ev_d[input_function_pkg::IRQ_ALARM]   = alarm_hit_w && !alarm_o;
    ev_d[input_function_pkg::IRQ_CFG_ERR] = cfg_err_d && !cfg_error_o;
    clr_d = '0;
    if (reg_wr_i && reg_addr_i == input_function_pkg::ADDR_IRQ_CLR)
      clr_d = reg_wdata_i[input_function_pkg::IRQ_W-1:0];
  end
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_stat_q <= '0;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~clr_d) | ev_d;
      irq_o      <= |(((irq_stat_q & ~clr_d) | ev_d) & irq_en_q);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= '0;
    else
    begin
      reg_rdata_o <= '0;
      if (reg_rd_i)
      begin
        if (reg_addr_i == input_function_pkg::ADDR_CODE_LO)
        begin
          for (int i = 0; i < 4 && i < NUM_IN; i++)
            reg_rdata_o[i*CW +: CW] <= code_q[i];
        end
        else if (reg_addr_i == input_function_pkg::ADDR_CODE_HI)
        begin
          for (int i = 4; i < NUM_IN; i++)
            reg_rdata_o[(i-4)*CW +: CW] <= code_q[i];
        end
        else if (reg_addr_i == input_function_pkg::ADDR_CTRL)
        begin
          reg_rdata_o[input_function_pkg::CTRL_FLUX_BIT] <= flux_q;
          reg_rdata_o[input_function_pkg::CTRL_OUTFN_LSB +: CW] <= outfn_q;
        end
        else if (reg_addr_i == input_function_pkg::ADDR_STATUS)
          reg_rdata_o[7:0] <= {cfg_error_o, speed_gain_second_o, zero_servo_o,
                               torque_mode_o, dc_brake_o | init_excite_o,
                               alarm_o, fault_o && fault_act_q == input_function_pkg::ACT_COAST,
                               fault_o};
        else if (reg_addr_i == input_function_pkg::ADDR_IRQ_STAT)
          reg_rdata_o[input_function_pkg::IRQ_W-1:0] <= irq_stat_q;
        else if (reg_addr_i == input_function_pkg::ADDR_IRQ_EN)
          reg_rdata_o[input_function_pkg::IRQ_W-1:0] <= irq_en_q;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/peripheral_contacts_model.sv ----
// Peripheral contacts and external run controller feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module peripheral_contacts_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] contact_req_i,
  input  wire logic [3:0] cmd_req_i,
  output logic      [7:0] din_o,
  output logic            run_o,
  output logic            jog_o,
  output logic            reset_o,
  output logic            ref_low_o
);
  // Contacts settle one cycle after the request; cmd is {ref, reset, jog, run}
  always_ff @(posedge mclk_i)
  begin
    din_o     <= contact_req_i;
    run_o     <= cmd_req_i[0];
    jog_o     <= cmd_req_i[1];
    reset_o   <= cmd_req_i[2];
    ref_low_o <= cmd_req_i[3];
  end
endmodule
`default_nettype wire

// ---- dv/drive_input_function_checker.sv ----
// Port assertions for the input function decoder
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_checker (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        run_cmd_i,
  input wire logic        jog_cmd_i,
  input wire logic        fault_reset_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        fault_o,
  input wire logic        decel_stop_o,
  input wire logic        coast_o,
  input wire logic        fast_stop_o,
  input wire logic        dc_brake_o,
  input wire logic        init_excite_o,
  input wire logic        search_start_o,
  input wire logic        cfg_error_o
);
  logic [3:0] rst_age_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Cycles since a fault reset was last requested
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_age_q <= 4'hF;
    else if (fault_reset_i)
      rst_age_q <= 4'h0;
    else if (rst_age_q != 4'hF)
      rst_age_q <= rst_age_q + 4'h1;
  end
  a_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside its slot");
  a_stop_after_fault: assert property (
    $rose(fault_o) |=> $onehot({decel_stop_o, coast_o, fast_stop_o}))
    else $error("fault without exactly one stop action");
  a_stop_needs_fault: assert property (
    (decel_stop_o || coast_o || fast_stop_o) |-> fault_o || $past(fault_o))
    else $error("stop action without fault");
  a_fault_held: assert property ($fell(fault_o) |-> rst_age_q < 4'hC)
    else $error("fault cleared without fault reset");
  a_cfg_masks_fault: assert property (cfg_error_o |-> !$rose(fault_o))
    else $error("fault raised under refused configuration");
  a_brake_exclusive: assert property (!(dc_brake_o && init_excite_o))
    else $error("braking and excitation together");
  a_run_ends_brake: assert property (
    $rose(run_cmd_i) || $rose(jog_cmd_i) |-> ##[1:8] !(dc_brake_o || init_excite_o))
    else $error("braking not ended by run or jog");
  a_search_pulse: assert property (search_start_o |=> !search_start_o)
    else $error("search start longer than one cycle");
  a_search_cfg: assert property (search_start_o |-> !cfg_error_o)
    else $error("search started under refused configuration");
endmodule
bind drive_input_function_decoder drive_input_function_checker u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .run_cmd_i(run_cmd_i), .jog_cmd_i(jog_cmd_i),
  .fault_reset_i(fault_reset_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .fault_o(fault_o), .decel_stop_o(decel_stop_o), .coast_o(coast_o),
  .fast_stop_o(fast_stop_o), .dc_brake_o(dc_brake_o), .init_excite_o(init_excite_o),
  .search_start_o(search_start_o), .cfg_error_o(cfg_error_o));
`default_nettype wire

// ---- dv/tb_drive_input_function_decoder.sv ----
// Testbench for the input function decoder
`timescale 1ns/1ps
`default_nettype none
module tb_drive_input_function_decoder;
  localparam int BB = 4;
  logic        mclk_i      = 1'b0;
  logic        rstn_i      = 1'b0;
  logic [7:0]  contact     = 8'h00;
  logic [3:0]  cmd         = 4'h0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  din_i;
  logic        run_cmd_i, jog_cmd_i, fault_reset_i, ref_below_zero_i;
  logic [31:0] reg_rdata_o;
  logic        fault_o, alarm_o, minor_fault_out_o, decel_stop_o, coast_o, fast_stop_o;
  logic        dc_brake_o, init_excite_o, search_start_o, search_from_max_o;
  logic        torque_mode_o, zero_servo_o, speed_gain_second_o, cfg_error_o, irq_o;
  int          num_errors  = 0;
  int          checks_done = 0;

  always #10 mclk_i = ~mclk_i;

  peripheral_contacts_model u_peer (.mclk_i, .contact_req_i(contact), .cmd_req_i(cmd),
    .din_o(din_i), .run_o(run_cmd_i), .jog_o(jog_cmd_i), .reset_o(fault_reset_i),
    .ref_low_o(ref_below_zero_i));

  drive_input_function_decoder #(.NUM_IN(8), .BB_CYC(BB)) dut (.mclk_i, .rstn_i, .din_i,
    .run_cmd_i, .jog_cmd_i, .fault_reset_i, .ref_below_zero_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fault_o, .alarm_o, .minor_fault_out_o,
    .decel_stop_o, .coast_o, .fast_stop_o, .dc_brake_o, .init_excite_o, .search_start_o,
    .search_from_max_o, .torque_mode_o, .zero_servo_o, .speed_gain_second_o,
    .cfg_error_o, .irq_o);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic drive(input logic [7:0] c, input logic [3:0] k);
    @(posedge mclk_i);
    contact <= c;
    cmd     <= k;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic ext_expect(input logic [1:0] act, input logic det, input logic mf);
    logic flt;
    flt = det && act != 2'h3;
    chk(fault_o, flt);
    chk(alarm_o, det && act == 2'h3);
    chk(minor_fault_out_o, det && act == 2'h3 && mf);
    chk(decel_stop_o, flt && act == 2'h0);
    chk(coast_o, flt && act == 2'h1);
    chk(fast_stop_o, flt && act == 2'h2);
    chk(irq_o, flt);
  endtask

  task automatic t_registers();
    reg_read(4'h3, 32'h0);
    reg_read(4'h4, 32'h0);
    reg_write(4'hF, 32'hFFFF_FFFF);
    reg_read(4'hF, 32'h0);
    reg_write(4'h1, 32'h0000_7277);
    reg_read(4'h1, 32'h0000_7277);
    reg_write(4'h1, 32'h0);
  endtask

  task automatic t_ext_faults();
    logic [7:0] code;
    reg_write(4'h2, 32'h0000_1000);
    reg_write(4'h5, 32'h1);
    reg_read(4'h2, 32'h0000_1000);
    reg_read(4'h5, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      code = 8'h20 + 8'(i);
      // Odd codes pick an output function other than the alarm one
      reg_write(4'h2, {16'h0, 7'h08, code[0], 8'h00});
      drive({7'h0, ~code[0]}, 4'h0);
      reg_write(4'h0, {24'h0, code});
      settle(10);
      ext_expect(code[3:2], !code[1], !code[0]);
      if (code[1])
      begin
        drive({7'h0, ~code[0]}, 4'h1);
        settle(10);
        ext_expect(code[3:2], 1'b1, !code[0]);
      end
      drive({7'h0, code[0]}, 4'h0);
      settle(10);
      chk(fault_o, code[3:2] != 2'h3);
      chk(alarm_o, 1'b0);
      reg_read(4'h4, {30'h0, code[3:2] == 2'h3, code[3:2] != 2'h3});
      reg_read(4'h3, {30'h0, code[3:2] == 2'h1, code[3:2] != 2'h3});
      drive({7'h0, code[0]}, 4'h4);
      settle(6);
      drive({7'h0, code[0]}, 4'h0);
      settle(10);
      chk(fault_o, 1'b0);
      reg_write(4'h6, 32'h7);
      settle(2);
      chk(irq_o, 1'b0);
    end
  endtask

  task automatic t_cfg_refuse();
    drive(8'h00, 4'h0);
    reg_write(4'h0, 32'h0000_2020);
    drive(8'h01, 4'h0);
    settle(10);
    chk(cfg_error_o, 1'b1);
    chk(fault_o, 1'b0);
    reg_read(4'h4, 32'h4);
    reg_write(4'h0, 32'h0000_6261);
    drive(8'h03, 4'h1);
    settle(BB + 12);
    chk(cfg_error_o, 1'b1);
    drive(8'h00, 4'h0);
    reg_write(4'h0, 32'h0);
    reg_write(4'h6, 32'h7);
    settle(8);
    chk(cfg_error_o, 1'b0);
  endtask

  task automatic t_dc_brake();
    reg_write(4'h0, 32'h60);
    for (int f = 0; f < 2; f++)
    begin
      reg_write(4'h2, {16'h0, 8'h10, 7'h0, f[0]});
      drive(8'h01, 4'h0);
      settle(8);
      chk(dc_brake_o, !f[0]);
      chk(init_excite_o, f[0]);
      drive(8'h01, f[0] ? 4'h2 : 4'h1);
      settle(10);
      chk(dc_brake_o | init_excite_o, 1'b0);
    end
    drive(8'h00, 4'h0);
    reg_write(4'h0, 32'h0);
  endtask

  task automatic t_search();
    int n;
    for (int s = 0; s < 2; s++)
    begin
      drive(8'h00, 4'h0);
      reg_write(4'h0, 32'h61 + 32'(s));
      drive(8'h01, 4'h0);
      settle(8);
      drive(8'h01, 4'h1);
      n = 0;
      do
      begin
        @(posedge mclk_i);
        #1;
        n++;
      end while (search_start_o !== 1'b1 && n < 100);
      chk(n >= BB + 3 && n <= BB + 12, 1'b1);
      chk(search_from_max_o, s == 0);
      drive(8'h00, 4'h0);
      settle(8);
    end
    reg_write(4'h0, 32'h0);
  endtask

  task automatic t_levels();
    reg_write(4'h0, 32'h0077_7271);
    for (int i = 0; i < 16; i++)
    begin
      drive({5'h0, i[2:0]}, {i[3], 3'h0});
      settle(8);
      chk(torque_mode_o, i[0]);
      chk(zero_servo_o, i[1] && i[3]);
      chk(speed_gain_second_o, i[2]);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_registers();
    t_ext_faults();
    t_cfg_refuse();
    t_dc_brake();
    t_search();
    t_levels();
    report_and_stop();
  end

  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
